//--- src/lia_defines.svh
`ifndef LIA_DEFINES_SVH
`define LIA_DEFINES_SVH

`define LIA_CLK_HZ 64'd50000000

// Register byte offsets
`define LIA_REG_CTRL 8'h00
`define LIA_REG_STATUS 8'h04
`define LIA_REG_MASK 8'h08
`define LIA_REG_STATE 8'h0c

// Control fields
`define LIA_CTRL_SLAVE 0
`define LIA_CTRL_DUAL 1
`define LIA_CTRL_RESET 2'h0

// Status and mask fields
`define LIA_EV_WHITE 0
`define LIA_EV_DAYERR 1
`define LIA_EV_RED 2
`define LIA_EV_NUM 3

// Timing, figures in their own unit
`define LIA_OVR_HOURS 64'd8
`define LIA_SYNC_SEC 64'd6
`define LIA_PEC_SEC 64'd60
`define LIA_FLASH_MS 64'd1500
`define LIA_PULSE_DAY_MS 64'd10
`define LIA_PULSE_NIGHT_MS 64'd30
`define LIA_MISS_LIMIT 2'd3

// Derived cycle counts
`define LIA_OVR_CYC (`LIA_OVR_HOURS * 64'd3600 * `LIA_CLK_HZ)
`define LIA_SYNC_CYC (`LIA_SYNC_SEC * `LIA_CLK_HZ)
`define LIA_PEC_CYC (`LIA_PEC_SEC * `LIA_CLK_HZ)
`define LIA_FLASH_CYC (`LIA_FLASH_MS * `LIA_CLK_HZ / 64'd1000)
`define LIA_PULSE_DAY_CYC (`LIA_PULSE_DAY_MS * `LIA_CLK_HZ / 64'd1000)
`define LIA_PULSE_NIGHT_CYC (`LIA_PULSE_NIGHT_MS * `LIA_CLK_HZ / 64'd1000)

`endif

//--- src/lia_pkg.sv
package lia_pkg;
  typedef enum logic [1:0] {LIA_SW_AUTO, LIA_SW_DAY, LIA_SW_NIGHT} lia_sw_e;
  typedef enum logic [1:0] {LIA_OVR_AUTO, LIA_OVR_MANUAL, LIA_OVR_EXPIRED} lia_ovr_e;
endpackage

//--- src/lia_ctrl.sv
`timescale 1ns/10ps
`include "lia_defines.svh"
module lia_ctrl
  import lia_pkg::*;
#(
  parameter logic [43:0] OVR_CYC = 44'(`LIA_OVR_CYC),
  parameter logic [31:0] SYNC_CYC = 32'(`LIA_SYNC_CYC),
  parameter logic [31:0] PEC_CYC = 32'(`LIA_PEC_CYC),
  parameter logic [31:0] FLASH_CYC = 32'(`LIA_FLASH_CYC),
  parameter logic [31:0] PULSE_DAY_CYC = 32'(`LIA_PULSE_DAY_CYC),
  parameter logic [31:0] PULSE_NIGHT_CYC = 32'(`LIA_PULSE_NIGHT_CYC)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic photocell_dark_i,
  input wire logic intensity_select_switch_day_i,
  input wire logic intensity_select_switch_night_i,
  input wire logic flash_detect_i,
  input wire logic red_controller_terminal_ok_i,
  input wire logic sync_interconnect_terminal_i,
  output logic sync_interconnect_terminal_o,
  output logic sync_interconnect_terminal_oe_o,
  output logic intensity_night_o,
  output logic flash_trigger_o,
  output logic red_enable_o,
  output logic marker_indicator_o,
  output logic sync_indicator_o,
  output logic white_failure_alarm_o,
  output logic day_error_o,
  output logic red_failure_alarm_o,
  output logic override_active_o,
  output logic irq_o
);

  // Two-stage synchronisers for every pin input
  logic [5:0] pin_meta_r;
  logic [5:0] pin_s_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_r <= 6'h00;
      pin_s_r <= 6'h00;
    end else begin
      pin_meta_r <= {photocell_dark_i, intensity_select_switch_day_i, intensity_select_switch_night_i,
                     flash_detect_i, red_controller_terminal_ok_i, sync_interconnect_terminal_i};
      pin_s_r <= pin_meta_r;
    end
  end
  logic dark_s, sw_day_s, sw_night_s, flash_s, red_ok_s, sync_in_s;
  assign {dark_s, sw_day_s, sw_night_s, flash_s, red_ok_s, sync_in_s} = pin_s_r;

  lia_sw_e sw_pos;
  always_comb begin
    if (sw_day_s && !sw_night_s) begin
      sw_pos = LIA_SW_DAY;
    end else if (sw_night_s && !sw_day_s) begin
      sw_pos = LIA_SW_NIGHT;
    end else begin
      sw_pos = LIA_SW_AUTO;
    end
  end

  // Register bus
  logic [1:0] ctrl_r;
  logic [`LIA_EV_NUM-1:0] status_r;
  logic [`LIA_EV_NUM-1:0] mask_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic slave_mode, dual_sys;
  assign slave_mode = ctrl_r[`LIA_CTRL_SLAVE];
  assign dual_sys = ctrl_r[`LIA_CTRL_DUAL];

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] offs);
    hit = (adr[7:2] == offs[7:2]);
  endfunction

  logic wr_en;
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end
  end
  assign wb_ack_o = ack_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `LIA_CTRL_RESET;
      mask_r <= '0;
    end else if (wr_en) begin
      if (hit(wb_adr_i, `LIA_REG_CTRL)) begin
        ctrl_r <= wb_dat_i[1:0];
      end
      if (hit(wb_adr_i, `LIA_REG_MASK)) begin
        mask_r <= wb_dat_i[`LIA_EV_NUM-1:0];
      end
    end
  end

  // Override timer state machine
  lia_ovr_e ovr_r;
  lia_sw_e pos_r;
  logic [43:0] ovr_cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovr_r <= LIA_OVR_AUTO;
      pos_r <= LIA_SW_AUTO;
      ovr_cnt_r <= 44'h0;
    end else begin
      case (ovr_r)
        LIA_OVR_AUTO: begin
          if (sw_pos != LIA_SW_AUTO) begin
            ovr_r <= LIA_OVR_MANUAL;
            pos_r <= sw_pos;
            ovr_cnt_r <= 44'h0;
          end
        end
        LIA_OVR_MANUAL: begin
          if (sw_pos == LIA_SW_AUTO) begin
            ovr_r <= LIA_OVR_AUTO;
          end else if (sw_pos != pos_r) begin
            pos_r <= sw_pos;
            ovr_cnt_r <= 44'h0;
          end else if (ovr_cnt_r == OVR_CYC - 44'h1) begin
            ovr_r <= LIA_OVR_EXPIRED;
          end else begin
            ovr_cnt_r <= ovr_cnt_r + 44'h1;
          end
        end
        LIA_OVR_EXPIRED: begin
          if (sw_pos == LIA_SW_AUTO) begin
            ovr_r <= LIA_OVR_AUTO;
          end else if (sw_pos != pos_r) begin
            // Moving to the other position counts as a fresh selection
            ovr_r <= LIA_OVR_MANUAL;
            pos_r <= sw_pos;
            ovr_cnt_r <= 44'h0;
          end
        end
        default: begin
          ovr_r <= LIA_OVR_AUTO;
        end
      endcase
    end
  end

  // Photocell startup hold
  logic [31:0] pec_cnt_r;
  logic pec_ready;
  assign pec_ready = (pec_cnt_r == PEC_CYC);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pec_cnt_r <= 32'h0;
    end else if (!pec_ready) begin
      pec_cnt_r <= pec_cnt_r + 32'h1;
    end
  end

  // Slave side: pulse width gives intensity, silence means a lost wire
  logic sync_in_d_r;
  logic [31:0] width_r;
  logic [31:0] quiet_r;
  logic link_ok_r;
  logic link_night_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_in_d_r <= 1'b0;
      width_r <= 32'h0;
      quiet_r <= 32'h0;
      link_ok_r <= 1'b0;
      link_night_r <= 1'b0;
    end else begin
      sync_in_d_r <= sync_in_s;
      if (sync_in_s) begin
        if (width_r != PULSE_NIGHT_CYC) begin
          width_r <= width_r + 32'h1;
        end
      end else begin
        width_r <= 32'h0;
      end
      if (sync_in_d_r && !sync_in_s) begin
        link_night_r <= (width_r >= ((PULSE_DAY_CYC + PULSE_NIGHT_CYC) >> 1));
        link_ok_r <= 1'b1;
        quiet_r <= 32'h0;
      end else if (quiet_r == (SYNC_CYC << 1)) begin
        link_ok_r <= 1'b0;
      end else begin
        quiet_r <= quiet_r + 32'h1;
      end
    end
  end

  // Intensity selection; manual positions assume the interconnect is unwired
  logic night_nxt;
  logic night_r;
  always_comb begin
    if (ovr_r == LIA_OVR_MANUAL) begin
      night_nxt = (pos_r == LIA_SW_NIGHT);
    end else if (slave_mode) begin
      night_nxt = link_ok_r && link_night_r;
    end else begin
      night_nxt = pec_ready && dark_s;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      night_r <= 1'b0;
    end else begin
      night_r <= night_nxt;
    end
  end

  // Master sync generator, width latched at the start of each period
  logic [31:0] sync_cnt_r;
  logic pulse_night_r;
  logic sync_out_r;
  logic sync_ind_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_cnt_r <= 32'h0;
      pulse_night_r <= 1'b0;
      sync_out_r <= 1'b0;
      sync_ind_r <= 1'b0;
    end else begin
      sync_cnt_r <= (sync_cnt_r == SYNC_CYC - 32'h1) ? 32'h0 : sync_cnt_r + 32'h1;
      if (sync_cnt_r == 32'h0) begin
        pulse_night_r <= night_r;
      end
      sync_out_r <= !slave_mode && (sync_cnt_r < (pulse_night_r ? PULSE_NIGHT_CYC : PULSE_DAY_CYC));
      sync_ind_r <= slave_mode ? sync_in_s : (sync_cnt_r < PULSE_DAY_CYC);
    end
  end
  assign sync_interconnect_terminal_o = sync_out_r;
  assign sync_interconnect_terminal_oe_o = !slave_mode;
  assign sync_indicator_o = sync_ind_r;

  // Flash trigger and missed-flash supervision
  logic red_fail_live;
  logic white_en;
  assign red_fail_live = dual_sys && night_r && !red_ok_s;
  assign white_en = !(dual_sys && night_r) || red_fail_live;

  logic [31:0] flash_cnt_r;
  logic flash_tick;
  logic flash_d_r;
  logic armed_r;
  logic seen_r;
  logic [1:0] miss_r;
  logic trig_r;
  logic white_evt;
  assign flash_tick = (flash_cnt_r == FLASH_CYC - 32'h1);
  assign white_evt = flash_tick && armed_r && !seen_r && (miss_r >= `LIA_MISS_LIMIT - 2'd1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_cnt_r <= 32'h0;
      flash_d_r <= 1'b0;
      armed_r <= 1'b0;
      seen_r <= 1'b0;
      miss_r <= 2'h0;
      trig_r <= 1'b0;
    end else begin
      flash_d_r <= flash_s;
      flash_cnt_r <= flash_tick ? 32'h0 : flash_cnt_r + 32'h1;
      trig_r <= flash_tick && white_en;
      if (flash_tick) begin
        armed_r <= white_en;
        seen_r <= 1'b0;
        if (armed_r) begin
          if (seen_r) begin
            miss_r <= 2'h0;
          end else if (miss_r != `LIA_MISS_LIMIT) begin
            miss_r <= miss_r + 2'h1;
          end
        end
      end else if (flash_s && !flash_d_r) begin
        seen_r <= 1'b1;
      end
    end
  end
  assign flash_trigger_o = trig_r;

  // Sticky status, set wins over a write-one clear
  logic [`LIA_EV_NUM-1:0] evt;
  assign evt[`LIA_EV_WHITE] = white_evt;
  assign evt[`LIA_EV_DAYERR] = white_evt && !night_r;
  assign evt[`LIA_EV_RED] = red_fail_live;

  genvar gi;
  generate
    for (gi = 0; gi < `LIA_EV_NUM; gi++) begin : g_status
      logic clr;
      assign clr = wr_en && hit(wb_adr_i, `LIA_REG_STATUS) && wb_dat_i[gi];
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          status_r[gi] <= 1'b0;
        end else begin
          status_r[gi] <= (status_r[gi] && !clr) || evt[gi];
        end
      end
    end
  endgenerate

  logic red_en_r;
  logic marker_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      red_en_r <= 1'b0;
      marker_r <= 1'b0;
    end else begin
      red_en_r <= dual_sys && night_r;
      marker_r <= 1'b0;
    end
  end

  // Read data captured on the request cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0;
    end else if (wb_cyc_i && wb_stb_i && !ack_r) begin
      if (hit(wb_adr_i, `LIA_REG_CTRL)) begin
        dat_r <= {30'h0, ctrl_r};
      end else if (hit(wb_adr_i, `LIA_REG_STATUS)) begin
        dat_r <= {29'h0, status_r};
      end else if (hit(wb_adr_i, `LIA_REG_MASK)) begin
        dat_r <= {29'h0, mask_r};
      end else if (hit(wb_adr_i, `LIA_REG_STATE)) begin
        dat_r <= {25'h0, miss_r, red_en_r, link_ok_r, ovr_r == LIA_OVR_EXPIRED, ovr_r == LIA_OVR_MANUAL, night_r};
      end else begin
        dat_r <= 32'h0;
      end
    end
  end
  assign wb_dat_o = dat_r;

  assign intensity_night_o = night_r;
  assign red_enable_o = red_en_r;
  assign marker_indicator_o = marker_r;
  assign white_failure_alarm_o = status_r[`LIA_EV_WHITE];
  assign day_error_o = status_r[`LIA_EV_DAYERR];
  assign red_failure_alarm_o = status_r[`LIA_EV_RED];
  assign override_active_o = (ovr_r == LIA_OVR_MANUAL);
  assign irq_o = |(status_r & mask_r);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ovr_timeout_a: assert property ((ovr_r == LIA_OVR_MANUAL) && (sw_pos == pos_r) &&
    (ovr_cnt_r == OVR_CYC - 44'h1) |=> (ovr_r == LIA_OVR_EXPIRED) ##1
    (night_r == $past(slave_mode ? (link_ok_r && link_night_r) : (pec_ready && dark_s))))
    else $error("override did not expire after its full time");
  auto_cancel_a: assert property ((ovr_r != LIA_OVR_AUTO) && (sw_pos == LIA_SW_AUTO) |=>
    (ovr_r == LIA_OVR_AUTO) && !override_active_o)
    else $error("return to automatic did not cancel override");
  day_auto_a: assert property ((ovr_r != LIA_OVR_MANUAL) && !slave_mode && !dark_s |=> !night_r)
    else $error("daylight in automatic gave night intensity");
  pec_hold_a: assert property ((ovr_r != LIA_OVR_MANUAL) && !slave_mode && !pec_ready |=> !night_r)
    else $error("night selected before photocell startup delay");
  white_fail_a: assert property (white_evt |=> white_failure_alarm_o && (miss_r == `LIA_MISS_LIMIT))
    else $error("white alarm not set on third missed flash");
  day_err_a: assert property (white_evt && !night_r |=> day_error_o && white_failure_alarm_o)
    else $error("day error not set with white alarm");
  dual_quiet_a: assert property (dual_sys && night_r && red_ok_s |=> !flash_trigger_o && !marker_indicator_o)
    else $error("white flashed during dual system night");
  red_fail_a: assert property (red_fail_live && flash_tick |=> flash_trigger_o && red_failure_alarm_o)
    else $error("red failure did not resume white or set alarm");
  sync_track_a: assert property (!slave_mode && (sync_cnt_r == 32'h0) |=> (pulse_night_r == $past(night_r)))
    else $error("sync width does not follow intensity");
  slave_loss_a: assert property (slave_mode && !link_ok_r && (ovr_r != LIA_OVR_MANUAL) |=> !night_r)
    else $error("slave without link left day operation");
  sync_ind_a: assert property (!slave_mode && $past(!slave_mode) && $rose(sync_indicator_o) |->
    ($past(sync_cnt_r) == 32'h0))
    else $error("sync indicator not aligned with period start");

  ovr_expire_c: cover property (ovr_r == LIA_OVR_MANUAL ##1 ovr_r == LIA_OVR_EXPIRED);
  white_fail_c: cover property (white_evt);
  red_fail_c: cover property (dual_sys && night_r ##1 red_fail_live);
  link_loss_c: cover property (slave_mode && link_ok_r ##1 !link_ok_r);

endmodule

//--- testbench/lia_far.sv
`timescale 1ns/10ps
module lia_far (
  input wire logic clk_i,
  input wire logic flash_trigger_i,
  input wire logic lamp_ok_i,
  input wire logic sync_run_i,
  input wire logic sync_night_i,
  output logic flash_detect_o,
  output logic sync_line_o
);
  logic [1:0] dly_r = 2'b00;
  logic [7:0] cnt_r = 8'h00;
  // Flash seen three cycles after the trigger, only while the lamp is healthy
  always_ff @(posedge clk_i) begin
    dly_r <= {dly_r[0], flash_trigger_i & lamp_ok_i};
    flash_detect_o <= dly_r[1];
  end
  // Remote master: pulse width carries intensity; pulled low when not running
  always_ff @(posedge clk_i) begin
    cnt_r <= (cnt_r == 8'hc7) ? 8'h00 : cnt_r + 8'h01;
    sync_line_o <= sync_run_i & (cnt_r < (sync_night_i ? 8'h0c : 8'h04));
  end
endmodule

//--- testbench/tb.sv
`timescale 1ns/10ps
`include "lia_defines.svh"
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'hf;
  logic [31:0] rdat;
  logic dark = 1'b0;
  logic sw_day = 1'b0;
  logic sw_night = 1'b0;
  logic red_ok = 1'b1;
  logic lamp_ok = 1'b1;
  logic sync_run = 1'b0;
  logic sync_night = 1'b0;
  logic flash_det, far_line, line, wb_ack_o, sync_o, sync_oe, night, trig;
  logic red_en, marker, sync_ind, wht, dayerr, redalm, ovr, irq;
  logic [31:0] wb_dat_o;
  int bad_count = 0;
  int n_tests = 0;
  int n_fl, n_si, n_sy;

  always #10 clk_i = ~clk_i;
  // The sync pin is shared: whoever enables its driver owns the line
  assign line = sync_oe ? sync_o : far_line;

  // Short timing so every timeout is reached within the run
  localparam logic [43:0] T_OVR = 44'd2000;
  localparam logic [31:0] T_SYNC = 32'd200;
  localparam logic [31:0] T_PEC = 32'd50;
  localparam logic [31:0] T_FLASH = 32'd40;
  localparam logic [31:0] T_DAY = 32'd4;
  localparam logic [31:0] T_NIGHT = 32'd12;

  lia_ctrl #(.OVR_CYC(T_OVR), .SYNC_CYC(T_SYNC), .PEC_CYC(T_PEC), .FLASH_CYC(T_FLASH),
    .PULSE_DAY_CYC(T_DAY), .PULSE_NIGHT_CYC(T_NIGHT)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .photocell_dark_i(dark), .intensity_select_switch_day_i(sw_day),
    .intensity_select_switch_night_i(sw_night), .flash_detect_i(flash_det),
    .red_controller_terminal_ok_i(red_ok), .sync_interconnect_terminal_i(line),
    .sync_interconnect_terminal_o(sync_o), .sync_interconnect_terminal_oe_o(sync_oe),
    .intensity_night_o(night), .flash_trigger_o(trig), .red_enable_o(red_en),
    .marker_indicator_o(marker), .sync_indicator_o(sync_ind), .white_failure_alarm_o(wht),
    .day_error_o(dayerr), .red_failure_alarm_o(redalm), .override_active_o(ovr), .irq_o(irq));

  lia_far u_far (.clk_i(clk_i), .flash_trigger_i(trig), .lamp_ok_i(lamp_ok), .sync_run_i(sync_run),
    .sync_night_i(sync_night), .flash_detect_o(flash_det), .sync_line_o(far_line));

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask

  // Holds the request until ack is sampled high, then idles one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
      n++;
    end
    chk("ack wait", 32'd1, 32'(n));
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(what, exp, rdat);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Counts flash triggers, indicator and sync-line high cycles over a window
  task automatic watch(input int n);
    n_fl = 0;
    n_si = 0;
    n_sy = 0;
    repeat (n) begin
      @(posedge clk_i);
      if (trig === 1'b1) n_fl++;
      if (sync_ind === 1'b1) n_si++;
      if (sync_o === 1'b1) n_sy++;
    end
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wt(3);
    rd("status", `LIA_REG_STATUS, 32'h0);
    rd("unmapped", 8'h10, 32'h0);
    wb(1'b1, 8'h10, 32'hff);
    rd("ctrl", `LIA_REG_CTRL, 32'h0);
    chk1("sync oe", 1'b1, sync_oe);
    // A write without the low byte lane must leave the fields alone
    sel <= 4'he;
    wb(1'b1, `LIA_REG_CTRL, 32'h3);
    sel <= 4'hf;
    rd("ctrl no lane", `LIA_REG_CTRL, 32'h0);
    wt(100);
    watch(200);
    chk1("night", 1'b0, night);
    chk("flashes", 32'd5, 32'(n_fl));
    chk("sync day", 32'd4, 32'(n_sy));
    chk("sync ind", 32'd4, 32'(n_si));
    dark <= 1'b1;
    wt(210);
    chk1("night", 1'b1, night);
    watch(200);
    chk("sync night", 32'd12, 32'(n_sy));
    chk("sync ind", 32'd4, 32'(n_si));
    chk("flashes", 32'd5, 32'(n_fl));
    wb(1'b1, `LIA_REG_CTRL, 32'h2);
    wt(5);
    watch(200);
    chk1("red enable", 1'b1, red_en);
    chk1("marker", 1'b0, marker);
    chk("flashes", 32'd0, 32'(n_fl));
    red_ok <= 1'b0;
    wt(5);
    watch(200);
    chk("flashes", 32'd5, 32'(n_fl));
    chk1("night", 1'b1, night);
    chk1("red alarm", 1'b1, redalm);
    chk1("white alarm", 1'b0, wht);
    rd("status", `LIA_REG_STATUS, 32'h4);
    chk1("irq masked", 1'b0, irq);
    wb(1'b1, `LIA_REG_MASK, 32'h4);
    chk1("irq", 1'b1, irq);
    red_ok <= 1'b1;
    wt(5);
    wb(1'b1, `LIA_REG_STATUS, 32'h4);
    rd("status", `LIA_REG_STATUS, 32'h0);
    chk1("irq", 1'b0, irq);
    wb(1'b1, `LIA_REG_CTRL, 32'h0);
    dark <= 1'b0;
    wb(1'b1, `LIA_REG_MASK, 32'h3);
    wt(5);
    lamp_ok <= 1'b0;
    wt(100);
    chk1("white alarm", 1'b0, wht);
    wt(100);
    chk1("white alarm", 1'b1, wht);
    chk1("day error", 1'b1, dayerr);
    chk1("irq", 1'b1, irq);
    rd("status", `LIA_REG_STATUS, 32'h3);
    lamp_ok <= 1'b1;
    wt(100);
    wb(1'b1, `LIA_REG_STATUS, 32'h3);
    rd("status", `LIA_REG_STATUS, 32'h0);
    // Far master stays silent while the override is in use
    sync_run <= 1'b0;
    sw_night <= 1'b1;
    wt(5);
    chk1("override", 1'b1, ovr);
    chk1("night", 1'b1, night);
    sw_night <= 1'b0;
    wt(5);
    chk1("override", 1'b0, ovr);
    chk1("night", 1'b0, night);
    dark <= 1'b1;
    sw_day <= 1'b1;
    wt(5);
    chk1("override", 1'b1, ovr);
    chk1("night", 1'b0, night);
    sw_day <= 1'b0;
    wt(5);
    chk1("night", 1'b1, night);
    dark <= 1'b0;
    sw_night <= 1'b1;
    wt(1900);
    chk1("night", 1'b1, night);
    wt(200);
    chk1("override", 1'b0, ovr);
    chk1("night", 1'b0, night);
    rd("state", `LIA_REG_STATE, 32'hc);
    sw_night <= 1'b0;
    wb(1'b1, `LIA_REG_CTRL, 32'h1);
    sync_run <= 1'b1;
    sync_night <= 1'b1;
    wt(450);
    chk1("sync oe", 1'b0, sync_oe);
    chk1("night", 1'b1, night);
    sync_run <= 1'b0;
    wt(500);
    chk1("night", 1'b0, night);
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    stop_test();
  end
endmodule
